// ### rtl/dsc_pkg.sv
// shared constants of the converter serial command port
package dsc_pkg;

  // frame layout, sent msb first
  localparam int FRAME_BITS = 24;
  localparam int WORD_BITS  = 16;
  localparam int ADDR_MSB   = 23;
  localparam int ADDR_LSB   = 16;

  // address byte commands
  localparam logic [7:0] CMD_IDLE     = 8'h00;
  localparam logic [7:0] CMD_CODE     = 8'h01;
  localparam logic [7:0] CMD_READ     = 8'h02;
  localparam logic [7:0] CMD_CONTROL  = 8'h55;
  localparam logic [7:0] CMD_RESET    = 8'h56;
  localparam logic [7:0] CMD_CONFIG   = 8'h57;
  localparam logic [7:0] CMD_GAIN     = 8'h58;
  localparam logic [7:0] CMD_OFFSET   = 8'h59;
  localparam logic [7:0] CMD_WD_KICK  = 8'h95;

  // read selector in data bits 5..0
  localparam int         RSEL_BITS    = 6;
  localparam logic [1:0] RSEL_STATUS  = 2'h0;
  localparam logic [1:0] RSEL_CODE    = 2'h1;
  localparam logic [1:0] RSEL_CONTROL = 2'h2;
  localparam logic [5:0] RSEL_CONFIG  = 6'h0B;
  localparam logic [5:0] RSEL_GAIN    = 6'h13;
  localparam logic [5:0] RSEL_OFFSET  = 6'h17;

  // register fields
  localparam logic [15:0] CONTROL_MASK = 16'h3FFF;
  localparam logic [15:0] CONFIG_MASK  = 16'h003F;
  localparam int          RANGE_LSB    = 0;
  localparam int          RANGE_BITS   = 3;
  localparam int          CHAIN_BIT    = 3;
  localparam int          RESET_BIT    = 0;

  // status flag positions
  localparam int ST_OVERTEMP = 0;
  localparam int ST_RAMP     = 1;
  localparam int ST_IFAULT   = 2;
  localparam int ST_WATCHDOG = 3;
  localparam int ST_FRAME    = 4;

  // reset values
  localparam logic [23:0] SHIFT_RESET = 24'h000000;
  localparam logic [15:0] REG_RESET   = 16'h0000;

  // serial clock limits against the 125 MHz system clock
  localparam int CLK_MHZ        = 125;
  localparam int SCLK_MAX_MHZ   = 30;
  localparam int SCLK_HALF_MIN  = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int SCLK_HALF_DFLT = 5;

  // controller wishbone map
  localparam logic [7:0] HOST_CONTROL = 8'h00;
  localparam logic [7:0] HOST_STATUS  = 8'h04;
  localparam logic [7:0] HOST_TX_BASE = 8'h10;
  localparam logic [7:0] HOST_RX_BASE = 8'h30;
  localparam int         HCTL_START   = 0;
  localparam int         HST_BUSY     = 0;
  localparam int         HST_DONE     = 1;

  // keep only the implemented code bits, low bits read as zero
  function automatic logic [15:0] code_fit(input logic [15:0] d, input int bits);
    logic [15:0] low;
    low = (16'h0001 << (16 - bits)) - 16'h0001;
    return d & ~low;
  endfunction : code_fit

endpackage : dsc_pkg

// ### rtl/dsc_link_if.sv
// four-wire serial link between controller and converter
`timescale 1ns/1ps
`default_nettype none
interface dsc_link_if;
  logic sclk;   // serial clock, made by the controller
  logic sdi;    // data into the converter
  logic latch;  // commit strobe, rising edge
  logic sdo;    // data out of the converter

  modport dev  (input sclk, input sdi, input latch, output sdo);
  modport host (output sclk, output sdi, output latch, input sdo);
endinterface : dsc_link_if
`default_nettype wire

// ### rtl/dsc_sync.sv
// two-flop synchroniser with edge pulses for slow link lines
`timescale 1ns/1ps
`default_nettype none
module dsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_i,   // sync reset, high
  input  wire logic             ce_i,    // clock enable
  input  wire logic [WIDTH-1:0] async_i, // lines from outside
  output logic      [WIDTH-1:0] level_o, // synchronised level
  output logic      [WIDTH-1:0] rise_o,  // one-cycle rise pulse
  output logic      [WIDTH-1:0] fall_o   // one-cycle fall pulse
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] last;
  } dsc_sync_state_t;

  dsc_sync_state_t r;
  dsc_sync_state_t next_r;

  // meta feeds stage only; edges are taken on stage and last
  always_comb begin
    next_r       = r;
    next_r.meta  = async_i;
    next_r.stage = r.meta;
    next_r.last  = r.stage;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign level_o = r.stage;
  assign rise_o  = r.stage & ~r.last;
  assign fall_o  = ~r.stage & r.last;
endmodule : dsc_sync
`default_nettype wire

// ### rtl/dsc_device.sv
// converter end of the serial command port: shift register, decode, registers
// Behaviour
// - frame is address byte then 16-bit word
// - sample sdi on each rising serial clock
// - shift always, commit on latch rising edge
// - host gives exactly 24 clocks per device
// - shift register clears at reset
// - decode nine address byte commands
// - read uses 0x02 with 6-bit selector
// - selector picks status, code, control, others
// - readback msb first on falling edges
// - host sends a further frame to read
// - clock continuous or burst, latch after
// - serial clock at most 30 MHz
// - chain enable passes shifted bits out
// - chain frame is N times 24 bits
// - chained read takes two frames
// - one latch commits all chained devices
// - gated clock burst exact, latch after
// - status is read-only fault flags
// - control register field layout
// - range change clears output code
// - configuration register field layout
// - narrow variant keeps bits 15..4 only
`timescale 1ns/1ps
`default_nettype none
module dsc_device #(
  parameter int CODE_BITS = 16
) (
  input  wire logic        clk_i,                   // system clock
  input  wire logic        rst_i,                   // sync reset, high
  input  wire logic        ce_i,                    // clock enable
  dsc_link_if.dev          link,                    // serial link
  input  wire logic        frame_check_error_i,     // status flag in
  input  wire logic        watchdog_timeout_flag_i, // status flag in
  input  wire logic        output_current_fault_i,  // status flag in
  input  wire logic        ramp_in_progress_i,      // status flag in
  input  wire logic        overtemp_flag_i,         // status flag in
  output logic      [15:0] output_code_o,           // output code register
  output logic      [15:0] output_control_o,        // control register
  output logic      [15:0] feature_configuration_o, // configuration register
  output logic      [15:0] gain_trim_o,             // gain trim register
  output logic      [15:0] offset_trim_o,           // offset trim register
  output logic             watchdog_restart_o       // pulse per restart command
);
  // synchronised line positions
  localparam int L_SDI   = 0;
  localparam int L_SCLK  = 1;
  localparam int L_LATCH = 2;

  typedef struct packed {
    logic [23:0] shift;
    logic        rb_active;
    logic        sdo;
    logic [15:0] code;
    logic [15:0] ctrl;
    logic [15:0] cfg;
    logic [15:0] gain;
    logic [15:0] offs;
    logic        wd_pulse;
  } dsc_dev_state_t;

  localparam dsc_dev_state_t DEV_RESET = '{
    shift:     dsc_pkg::SHIFT_RESET,
    rb_active: 1'b0,
    sdo:       1'b0,
    code:      dsc_pkg::REG_RESET,
    ctrl:      dsc_pkg::REG_RESET,
    cfg:       dsc_pkg::REG_RESET,
    gain:      dsc_pkg::REG_RESET,
    offs:      dsc_pkg::REG_RESET,
    wd_pulse:  1'b0
  };

  dsc_dev_state_t r;
  dsc_dev_state_t next_r;
  logic [2:0]     lvl;
  logic [2:0]     rise;
  logic [2:0]     fall;
  logic [7:0]     addr;
  logic [15:0]    word;
  logic [15:0]    status;
  logic [15:0]    rb_word;
  logic           chain_on;

  // all three link lines pass the same two flops, so sdi stays aligned to sclk
  dsc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i ({link.latch, link.sclk, link.sdi}),
    .level_o (lvl),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // frame fields and chain bit
  assign addr     = r.shift[dsc_pkg::ADDR_MSB:dsc_pkg::ADDR_LSB];
  assign word     = r.shift[dsc_pkg::WORD_BITS-1:0];
  assign chain_on = r.ctrl[dsc_pkg::CHAIN_BIT];

  // read-only status word, unused bits zero
  always_comb begin
    status                        = '0;
    status[dsc_pkg::ST_FRAME]     = frame_check_error_i;
    status[dsc_pkg::ST_WATCHDOG]  = watchdog_timeout_flag_i;
    status[dsc_pkg::ST_IFAULT]    = output_current_fault_i;
    status[dsc_pkg::ST_RAMP]      = ramp_in_progress_i;
    status[dsc_pkg::ST_OVERTEMP]  = overtemp_flag_i;
  end

  // readback selection; unlisted selectors with low bits 11 return zero
  always_comb begin
    rb_word = '0;
    if (word[dsc_pkg::RSEL_BITS-1:0] == dsc_pkg::RSEL_CONFIG) begin
      rb_word = r.cfg;
    end else if (word[dsc_pkg::RSEL_BITS-1:0] == dsc_pkg::RSEL_GAIN) begin
      rb_word = r.gain;
    end else if (word[dsc_pkg::RSEL_BITS-1:0] == dsc_pkg::RSEL_OFFSET) begin
      rb_word = r.offs;
    end else if (word[1:0] == dsc_pkg::RSEL_STATUS) begin
      rb_word = status;
    end else if (word[1:0] == dsc_pkg::RSEL_CODE) begin
      rb_word = r.code;
    end else if (word[1:0] == dsc_pkg::RSEL_CONTROL) begin
      rb_word = r.ctrl;
    end
  end

  // shift, drive sdo and commit on the latch edge
  always_comb begin
    next_r          = r;
    next_r.wd_pulse = 1'b0;
    if (rise[L_LATCH]) begin
      // a readback lives for one frame only
      next_r.rb_active = 1'b0;
      case (addr)
        dsc_pkg::CMD_CODE: begin
          next_r.code = dsc_pkg::code_fit(word, CODE_BITS);
        end
        dsc_pkg::CMD_READ: begin
          // leading byte of zeros reads as an idle command further down a chain
          next_r.shift     = {8'h00, rb_word};
          next_r.rb_active = 1'b1;
          next_r.sdo       = 1'b0;
        end
        dsc_pkg::CMD_CONTROL: begin
          next_r.ctrl = word & dsc_pkg::CONTROL_MASK;
          if (word[dsc_pkg::RANGE_LSB +: dsc_pkg::RANGE_BITS]
              != r.ctrl[dsc_pkg::RANGE_LSB +: dsc_pkg::RANGE_BITS]) begin
            next_r.code = dsc_pkg::REG_RESET;
          end
        end
        dsc_pkg::CMD_RESET: begin
          if (word[dsc_pkg::RESET_BIT]) begin
            next_r = DEV_RESET;
          end
        end
        dsc_pkg::CMD_CONFIG: begin
          next_r.cfg = word & dsc_pkg::CONFIG_MASK;
        end
        dsc_pkg::CMD_GAIN: begin
          next_r.gain = dsc_pkg::code_fit(word, CODE_BITS);
        end
        dsc_pkg::CMD_OFFSET: begin
          next_r.offs = dsc_pkg::code_fit(word, CODE_BITS);
        end
        dsc_pkg::CMD_WD_KICK: begin
          next_r.wd_pulse = 1'b1;
        end
        default: begin
          // idle command and unknown bytes leave registers alone
          next_r.code = r.code;
        end
      endcase
      // last fall is lost to the commit, so present the chained msb here
      if (next_r.ctrl[dsc_pkg::CHAIN_BIT]) begin
        next_r.sdo = next_r.shift[dsc_pkg::FRAME_BITS-1];
      end
    end else begin
      // bits shift regardless of the latch level
      if (rise[L_SCLK]) begin
        next_r.shift = {r.shift[dsc_pkg::FRAME_BITS-2:0], lvl[L_SDI]};
      end
      // msb after each shift leaves on the next rising edge; present it now
      if (fall[L_SCLK]) begin
        next_r.sdo = (chain_on || r.rb_active) ?
                     r.shift[dsc_pkg::FRAME_BITS-1] : 1'b0;
      end
    end
  end

  // state register; soft reset shares the same reset image
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= DEV_RESET;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  // outputs straight from state flops
  assign link.sdo                = r.sdo;
  assign output_code_o           = r.code;
  assign output_control_o        = r.ctrl;
  assign feature_configuration_o = r.cfg;
  assign gain_trim_o             = r.gain;
  assign offset_trim_o           = r.offs;
  assign watchdog_restart_o      = r.wd_pulse;
endmodule : dsc_device
`default_nettype wire

// ### rtl/dsc_host.sv
// controller end: wishbone registers drive whole frames onto the serial link
`timescale 1ns/1ps
`default_nettype none
module dsc_host #(
  parameter int DEVICES   = 1,                      // devices in the chain
  parameter int SCLK_HALF = dsc_pkg::SCLK_HALF_DFLT // clk cycles per sclk half
) (
  input  wire logic        clk_i,    // system clock
  input  wire logic        rst_i,    // sync reset, high
  input  wire logic        ce_i,     // clock enable
  input  wire logic        wb_cyc_i, // wishbone cycle
  input  wire logic        wb_stb_i, // wishbone strobe
  input  wire logic        wb_we_i,  // wishbone write
  input  wire logic [7:0]  wb_adr_i, // byte address
  input  wire logic [3:0]  wb_sel_i, // byte lanes
  input  wire logic [31:0] wb_dat_i, // write data
  output logic      [31:0] wb_dat_o, // read data
  output logic             wb_ack_o, // acknowledge
  dsc_link_if.host         link      // serial link
);
  localparam int         TOTAL = DEVICES * dsc_pkg::FRAME_BITS;
  localparam int         CNT_W = $clog2(TOTAL + 1);
  localparam int         DIV_W = $clog2(SCLK_HALF + 1);
  localparam logic [7:0] SPAN  = 8'(4 * DEVICES);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_LOW   = 3'b001,
    H_HIGH  = 3'b010,
    H_LATCH = 3'b011,
    H_GAP   = 3'b100
  } dsc_host_st_t;

  typedef struct packed {
    dsc_host_st_t              st;
    logic [DIV_W-1:0]          div;
    logic [CNT_W-1:0]          bits;
    logic [TOTAL-1:0]          tx;
    logic [TOTAL-1:0]          rx;
    logic [DEVICES-1:0][23:0]  txw;
    logic [DEVICES-1:0][23:0]  rxw;
    logic                      sclk;
    logic                      sdi;
    logic                      latch;
    logic                      busy;
    logic                      done;
    logic                      ack;
    logic [31:0]               dat;
  } dsc_host_state_t;

  dsc_host_state_t r;
  dsc_host_state_t next_r;
  logic            sdo_s;
  logic            req;
  logic            start;
  logic [7:0]      tx_off;
  logic [7:0]      rx_off;

  // sdo comes from another device's timing, so it is synchronised
  dsc_sync #(
    .WIDTH (1)
  ) u_sdo_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (link.sdo),
    .level_o (sdo_s),
    .rise_o  (),
    .fall_o  ()
  );

  // merge write data into a word by byte lane
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  assign req    = wb_cyc_i && wb_stb_i && !r.ack;
  assign tx_off = wb_adr_i - dsc_pkg::HOST_TX_BASE;
  assign rx_off = wb_adr_i - dsc_pkg::HOST_RX_BASE;
  assign start  = req && wb_we_i && (wb_adr_i == dsc_pkg::HOST_CONTROL) && wb_sel_i[0]
                  && wb_dat_i[dsc_pkg::HCTL_START] && !r.busy;

  always_comb begin
    next_r     = r;
    next_r.ack = req;
    // bus side first, so a frame end in the same cycle wins over a done clear
    if (req && wb_we_i) begin
      if (wb_adr_i == dsc_pkg::HOST_STATUS && wb_sel_i[0] && wb_dat_i[dsc_pkg::HST_DONE]) begin
        next_r.done = 1'b0;
      end else if (tx_off < SPAN && !r.busy) begin
        // frame words are locked while a frame runs
        next_r.txw[tx_off[7:2]] = 24'(lane_merge({8'h00, r.txw[tx_off[7:2]]}, wb_dat_i,
                                                 wb_sel_i));
      end
    end else if (req) begin
      next_r.dat = '0;
      if (wb_adr_i == dsc_pkg::HOST_STATUS) begin
        next_r.dat[dsc_pkg::HST_BUSY] = r.busy;
        next_r.dat[dsc_pkg::HST_DONE] = r.done;
      end else if (tx_off < SPAN) begin
        next_r.dat = {8'h00, r.txw[tx_off[7:2]]};
      end else if (rx_off < SPAN) begin
        next_r.dat = {8'h00, r.rxw[rx_off[7:2]]};
      end
    end
    // frame engine; farthest device word goes first
    unique case (r.st)
      H_IDLE: begin
        if (start) begin
          next_r.tx   = r.txw;
          next_r.sdi  = r.txw[DEVICES-1][23];
          next_r.div  = '0;
          next_r.bits = '0;
          next_r.busy = 1'b1;
          next_r.st   = H_LOW;
        end
      end
      H_LOW: begin
        next_r.div = r.div + 1'b1;
        if (r.div == DIV_W'(SCLK_HALF - 1)) begin
          next_r.div  = '0;
          next_r.sclk = 1'b1;
          next_r.st   = H_HIGH;
        end
      end
      H_HIGH: begin
        next_r.div = r.div + 1'b1;
        if (r.div == DIV_W'(SCLK_HALF - 1)) begin
          // sdo bit was set up after the previous fall; take it before this one
          next_r.div  = '0;
          next_r.sclk = 1'b0;
          next_r.rx   = {r.rx[TOTAL-2:0], sdo_s};
          next_r.bits = r.bits + 1'b1;
          if (r.bits == CNT_W'(TOTAL - 1)) begin
            next_r.latch = 1'b1;
            next_r.st    = H_LATCH;
          end else begin
            next_r.tx  = {r.tx[TOTAL-2:0], 1'b0};
            next_r.sdi = r.tx[TOTAL-2];
            next_r.st  = H_LOW;
          end
        end
      end
      H_LATCH: begin
        next_r.div = r.div + 1'b1;
        if (r.div == DIV_W'(SCLK_HALF - 1)) begin
          next_r.div   = '0;
          next_r.latch = 1'b0;
          next_r.rxw   = r.rx;
          next_r.st    = H_GAP;
        end
      end
      H_GAP: begin
        next_r.div = r.div + 1'b1;
        if (r.div == DIV_W'(SCLK_HALF - 1)) begin
          next_r.div  = '0;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st   = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r    <= '0;
      r.st <= H_IDLE;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign wb_dat_o   = r.dat;
  assign wb_ack_o   = r.ack;
  assign link.sclk  = r.sclk;
  assign link.sdi   = r.sdi;
  assign link.latch = r.latch;
endmodule : dsc_host
`default_nettype wire

// ### dv/dsc_asserts.sv
// wire-level checker for the serial link between controller and converter
`timescale 1ns/1ps
`default_nettype none
module dsc_asserts #(
  parameter int DEVICES   = 1,
  parameter int SCLK_HALF = 5
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  input wire logic sclk,  // serial clock
  input wire logic sdi,   // data into converter
  input wire logic latch, // commit strobe
  input wire logic sdo    // data out of converter
);
  logic [7:0] rises;   // sclk rises since last latch
  logic [7:0] srun;    // samples the sclk level has lasted
  logic [7:0] lrun;    // samples the latch level has lasted
  logic [4:0] sclk_h;  // sclk history, bit 0 newest
  logic [4:0] latch_h; // latch history, bit 0 newest
  logic       cause;   // a recent sclk fall or latch rise

  // history and run-length counters; runs restart on every level change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rises   <= 8'h00;
      srun    <= 8'h00;
      lrun    <= 8'h00;
      sclk_h  <= 5'h00;
      latch_h <= 5'h00;
    end else begin
      sclk_h  <= {sclk_h[3:0], sclk};
      latch_h <= {latch_h[3:0], latch};
      srun    <= (sclk != sclk_h[0]) ? 8'h01 : srun + 8'h01;
      lrun    <= (latch != latch_h[0]) ? 8'h01 : lrun + 8'h01;
      if (latch && !latch_h[0]) rises <= 8'h00;
      else if (sclk && !sclk_h[0]) rises <= rises + 8'h01;
    end
  end

  // sdo may only move shortly after a real sclk fall or latch rise
  assign cause = (|(sclk_h[4:1] & ~sclk_h[3:0])) | (sclk_h[0] & ~sclk)
               | (|(~latch_h[4:1] & latch_h[3:0])) | (~latch_h[0] & latch);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_latch_after_count: assert property ($rose(latch) |-> rises == 8'(24 * DEVICES))
    else $error("latch rose after a wrong number of clocks");
  a_no_extra_clocks: assert property ($rose(sclk) |-> rises < 8'(24 * DEVICES))
    else $error("more serial clocks than the chain holds");
  a_sclk_high_half: assert property ($fell(sclk) |-> srun == 8'(SCLK_HALF))
    else $error("serial clock high phase too short or long");
  a_sclk_low_half: assert property ($rose(sclk) && rises != 8'h00 |-> srun == 8'(SCLK_HALF))
    else $error("serial clock low phase too short or long");
  a_sdi_stable_high: assert property (sclk |-> $stable(sdi))
    else $error("data in moved while serial clock high");
  a_latch_clock_low: assert property (latch |-> !sclk)
    else $error("serial clock active during latch");
  a_gap_after_latch: assert property ($fell(latch) |-> !sclk [*3])
    else $error("serial clock resumed right after latch");
  a_latch_width: assert property ($fell(latch) |-> lrun == 8'(SCLK_HALF))
    else $error("latch pulse of wrong width");
  a_sdo_on_fall: assert property ($changed(sdo) |-> cause)
    else $error("data out changed without a clock fall or latch");

  cover property ($rose(latch));
endmodule : dsc_asserts
`default_nettype wire

// ### dv/dac_serial_command_port_test.sv
// self-checking bench: controller and converter joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module dac_serial_command_port_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack;
  logic [4:0]  flags = 5'h15;
  logic        ce    = 1'b1;
  logic [3:0]  lanes = 4'hF;
  logic [15:0] code_o, ctl_o, cfg_o, gain_o, offs_o;
  logic        kick_o;
  int          kicks = 0;
  int          cycles = 0;
  int          mismatches = 0;
  int          total_checks = 0;

  dsc_link_if lnk ();

  // 125 MHz system clock
  always #4 clk_i = ~clk_i;

  dsc_host #(.DEVICES(1), .SCLK_HALF(5)) dsc_host_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(lanes), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .link(lnk));

  dsc_device #(.CODE_BITS(16)) dsc_device_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .link(lnk),
    .frame_check_error_i(flags[4]), .watchdog_timeout_flag_i(flags[3]),
    .output_current_fault_i(flags[2]), .ramp_in_progress_i(flags[1]),
    .overtemp_flag_i(flags[0]), .output_code_o(code_o), .output_control_o(ctl_o),
    .feature_configuration_o(cfg_o), .gain_trim_o(gain_o), .offset_trim_o(offs_o),
    .watchdog_restart_o(kick_o));

  dsc_asserts #(.DEVICES(1), .SCLK_HALF(5)) dsc_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .sclk(lnk.sclk), .sdi(lnk.sdi),
    .latch(lnk.latch), .sdo(lnk.sdo));

  // restart pulses counted per cycle, so a stretched pulse shows up
  always @(posedge clk_i) begin
    if (kick_o === 1'b1) kicks <= kicks + 1;
  end

  // hang guard, far above the run's real length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic wishbone cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // load one 24-bit word, start, wait for done, clear done
  task automatic frame(input logic [23:0] w);
    logic [31:0] s;
    wb(1'b1, dsc_pkg::HOST_TX_BASE, {8'h00, w}, s);
    wb(1'b1, dsc_pkg::HOST_CONTROL, 32'h0000_0001, s);
    wb(1'b0, dsc_pkg::HOST_STATUS, 32'h0, s);
    check("busy", {31'h0, s[0]}, 32'h1);
    while (s[1] !== 1'b1) wb(1'b0, dsc_pkg::HOST_STATUS, 32'h0, s);
    wb(1'b1, dsc_pkg::HOST_STATUS, 32'h0000_0002, s);
  endtask : frame

  task automatic chk_regs(input logic [15:0] c, k, f, g, o);
    check("output_code", {16'h0, code_o}, {16'h0, c});
    check("output_control", {16'h0, ctl_o}, {16'h0, k});
    check("feature_configuration", {16'h0, cfg_o}, {16'h0, f});
    check("gain_trim", {16'h0, gain_o}, {16'h0, g});
    check("offset_trim", {16'h0, offs_o}, {16'h0, o});
  endtask : chk_regs

  // main sequence
  initial begin
    logic [31:0] q;
    logic [5:0]  sel [6];
    logic [15:0] want [6];
    int          k0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_regs(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    wb(1'b0, 8'h80, 32'h0, q);
    check("unmapped", q, 32'h0);
    frame({dsc_pkg::CMD_CODE, 16'hABCD});
    frame({dsc_pkg::CMD_GAIN, 16'h1234});
    frame({dsc_pkg::CMD_OFFSET, 16'h8765});
    frame({dsc_pkg::CMD_CONFIG, 16'hFFFF});
    chk_regs(16'hABCD, 16'h0, 16'h003F, 16'h1234, 16'h8765);
    // range moves 000 to 101, so the code must clear
    frame({dsc_pkg::CMD_CONTROL, 16'hF0F5});
    chk_regs(16'h0, 16'h30F5, 16'h003F, 16'h1234, 16'h8765);
    frame({dsc_pkg::CMD_CODE, 16'h5A5A});
    frame({dsc_pkg::CMD_CONTROL, 16'h30F5});
    frame({dsc_pkg::CMD_IDLE, 16'hFFFF});
    frame({8'h33, 16'hFFFF});
    // chain mode: each frame returns the word committed before it
    frame({dsc_pkg::CMD_CONTROL, 16'h30FD});
    frame({dsc_pkg::CMD_IDLE, 16'hBEEF});
    wb(1'b0, dsc_pkg::HOST_RX_BASE, 32'h0, q);
    check("chain_out", q, {8'h00, dsc_pkg::CMD_CONTROL, 16'h30FD});
    frame({dsc_pkg::CMD_CONTROL, 16'h30F5});
    wb(1'b0, dsc_pkg::HOST_RX_BASE, 32'h0, q);
    check("chain_idle", q, {8'h00, dsc_pkg::CMD_IDLE, 16'hBEEF});
    chk_regs(16'h5A5A, 16'h30F5, 16'h003F, 16'h1234, 16'h8765);
    // every selector, with the ignored upper bits set
    sel = '{6'h3C, 6'h3D, 6'h3E, 6'h0B, 6'h13, 6'h17};
    want = '{{11'h0, flags}, 16'h5A5A, 16'h30F5, 16'h003F, 16'h1234, 16'h8765};
    for (int i = 0; i < 6; i++) begin
      frame({dsc_pkg::CMD_READ, 10'h3FF, sel[i]});
      frame(24'h000000);
      wb(1'b0, dsc_pkg::HOST_RX_BASE, 32'h0, q);
      check("readback", q, {16'h0, want[i]});
    end
    // status follows the live flags, every bit flipped
    flags <= 5'h0A;
    frame({dsc_pkg::CMD_READ, 16'h0000});
    frame(24'h000000);
    wb(1'b0, dsc_pkg::HOST_RX_BASE, 32'h0, q);
    check("status", q, 32'h0000_000A);
    k0 = kicks;
    frame({dsc_pkg::CMD_WD_KICK, 16'h0000});
    check("restart_pulses", 32'(kicks), 32'(k0 + 1));
    frame({dsc_pkg::CMD_RESET, 16'h0000});
    chk_regs(16'h5A5A, 16'h30F5, 16'h003F, 16'h1234, 16'h8765);
    frame({dsc_pkg::CMD_RESET, 16'h0001});
    chk_regs(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    // frozen enable leaves a request unanswered; only lane 1 lands
    lanes <= 4'h2;
    ce    <= 1'b0;
    fork
      wb(1'b1, dsc_pkg::HOST_TX_BASE, 32'hFFFF_FFFF, q);
      begin
        repeat (10) @(posedge clk_i);
        check("ack_frozen", {31'h0, ack}, 32'h0);
        ce <= 1'b1;
      end
    join
    lanes <= 4'hF;
    wb(1'b0, dsc_pkg::HOST_TX_BASE, 32'h0, q);
    check("tx_lanes", q, {8'h00, dsc_pkg::CMD_RESET, 8'hFF, 8'h01});
    tally_and_finish();
  end
endmodule : dac_serial_command_port_test
`default_nettype wire
